// ### src/regc_pkg.sv
// Purpose: constants and types for rail enable gating and configuration
// Assumes: single 250 MHz clock, byte-wide registers on a plain port
// Notes: power-good inputs arrive asynchronously and are synchronised first
package regc_pkg;

  // Register offsets
  localparam logic [7:0] OFS_RAIL3_MASK  = 8'h0A;
  localparam logic [7:0] OFS_RAIL2_SRC   = 8'h0B;
  localparam logic [7:0] OFS_RAIL2_DLY   = 8'h0C;
  localparam logic [7:0] OFS_RAIL2_MASK  = 8'h20;
  localparam logic [7:0] OFS_STATUS      = 8'h21;

  // Reset values
  localparam logic [7:0] RST_RAIL3_MASK  = 8'h00;
  localparam logic [7:0] RST_RAIL2_SRC   = 8'hC0;
  localparam logic [7:0] RST_RAIL2_DLY   = 8'h00;
  localparam logic [7:0] RST_RAIL2_MASK  = 8'h00;

  // Field positions in the source/step/mask register
  localparam int POS_VSTEP     = 5;
  localparam int POS_SRC_HI    = 4;
  localparam int POS_SRC_LO    = 2;
  localparam int POS_MASK_PAIR = 1;
  localparam int POS_MASK_B1   = 0;
  // Field positions in the delay register
  localparam int POS_FALL_HI   = 5;
  localparam int POS_FALL_LO   = 3;
  localparam int POS_RISE_HI   = 2;
  localparam int POS_RISE_LO   = 0;

  // Power-good input index
  localparam int PG_STEP1   = 0;
  localparam int PG_STEP2   = 1;
  localparam int PG_STEP3   = 2;
  localparam int PG_STEP4   = 3;
  localparam int PG_STEP5   = 4;
  localparam int PG_STEP6   = 5;
  localparam int PG_SW_A1   = 6;
  localparam int PG_LDO2    = 7;
  localparam int PG_LDO3    = 8;
  localparam int PG_PAIR_B2 = 9;
  localparam int PG_SW_B1   = 10;
  localparam int PG_COUNT   = 11;
  localparam int CTL_COUNT  = 6;

  // Timing
  localparam int NS_PER_MS     = 1000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CYCLES_PER_MS = (NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W         = 18;
  localparam int MS_W          = 7;

  // Edge delays in ms per code
  localparam logic [MS_W-1:0] DLY_MS_0 = 7'h00;
  localparam logic [MS_W-1:0] DLY_MS_1 = 7'h02;
  localparam logic [MS_W-1:0] DLY_MS_2 = 7'h04;
  localparam logic [MS_W-1:0] DLY_MS_3 = 7'h08;
  localparam logic [MS_W-1:0] DLY_MS_4 = 7'h10;
  localparam logic [MS_W-1:0] DLY_MS_5 = 7'h18;
  localparam logic [MS_W-1:0] DLY_MS_6 = 7'h20;
  localparam logic [MS_W-1:0] DLY_MS_7 = 7'h40;

  typedef enum logic {ST_STEADY, ST_WAIT} regc_dly_state_type;

  function automatic logic [MS_W-1:0] regc_delay_ms(input logic [2:0] code);
    logic [MS_W-1:0] ms;
    ms = DLY_MS_0;
    unique case (code)
      3'h0: ms = DLY_MS_0;
      3'h1: ms = DLY_MS_1;
      3'h2: ms = DLY_MS_2;
      3'h3: ms = DLY_MS_3;
      3'h4: ms = DLY_MS_4;
      3'h5: ms = DLY_MS_5;
      3'h6: ms = DLY_MS_6;
      3'h7: ms = DLY_MS_7;
    endcase
    return ms;
  endfunction

endpackage

// ### src/regc_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels, not pulses
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module regc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_r;

endmodule

// ### src/regc_top.sv
// Purpose: enable gating for the second and third rails, edge delays for the second rail only
// Assumes: pins and power-good flags are asynchronous levels
// Notes: delay timebase restarts on each pending edge, so error is exactly one cycle
`timescale 1ns/1ps
module regc_top
  import regc_pkg::*;
#(
  parameter int MS_CYCLES = regc_pkg::CYCLES_PER_MS
) (
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  input  wire logic [regc_pkg::CTL_COUNT-1:0] control_in,
  input  wire logic [regc_pkg::PG_COUNT-1:0]  power_good_flag,
  input  wire logic                          rail3_request,
  output logic                               rail2_enable,
  output logic                               rail3_enable,
  output logic                               rail2_vstep_select
);
  import regc_pkg::*;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

  logic [7:0]         mask3_r, mask3_nxt;
  logic [7:0]         src2_r, src2_nxt;
  logic [7:0]         dly2_r, dly2_nxt;
  logic [7:0]         mask2_r, mask2_nxt;
  logic [7:0]         rdata_r, rdata_nxt;
  logic [CTL_COUNT-1:0] ctl_s;
  logic [PG_COUNT-1:0]  pg_s;
  logic               req3_s;
  logic [2:0]         sel2;
  logic               src2;
  logic [7:0]         pg2_vec;
  logic [7:0]         pg3_vec;
  logic               good2;
  logic               good3;
  logic               req2;
  logic               req3;
  regc_dly_state_type st_r, st_nxt;
  logic               out2_r, out2_nxt;
  logic               out3_r, out3_nxt;
  logic [DIV_W-1:0]   div_r, div_nxt;
  logic [MS_W-1:0]    ms_r, ms_nxt;
  logic [MS_W-1:0]    target_ms;

  regc_sync #(.WIDTH(CTL_COUNT + PG_COUNT + 1)) u_sync (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in ({rail3_request, power_good_flag, control_in}),
    .sync_out ({req3_s, pg_s, ctl_s})
  );

  // Register file
  always_comb begin
    mask3_nxt = mask3_r;
    src2_nxt  = src2_r;
    dly2_nxt  = dly2_r;
    mask2_nxt = mask2_r;
    rdata_nxt = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_RAIL3_MASK: mask3_nxt = reg_wdata;
        OFS_RAIL2_SRC:  src2_nxt  = reg_wdata;
        OFS_RAIL2_DLY:  dly2_nxt  = reg_wdata;
        OFS_RAIL2_MASK: mask2_nxt = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_RAIL3_MASK: rdata_nxt = mask3_r;
        OFS_RAIL2_SRC:  rdata_nxt = src2_r;
        OFS_RAIL2_DLY:  rdata_nxt = dly2_r;
        OFS_RAIL2_MASK: rdata_nxt = mask2_r;
        OFS_STATUS:     rdata_nxt = {4'h0, req2, st_r == ST_WAIT, out3_r, out2_r};
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mask3_r <= RST_RAIL3_MASK;
      src2_r  <= RST_RAIL2_SRC;
      dly2_r  <= RST_RAIL2_DLY;
      mask2_r <= RST_RAIL2_MASK;
      rdata_r <= 8'h00;
    end else begin
      mask3_r <= mask3_nxt;
      src2_r  <= src2_nxt;
      dly2_r  <= dly2_nxt;
      mask2_r <= mask2_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  assign rail2_vstep_select = src2_r[POS_VSTEP];

  assign sel2 = src2_r[POS_SRC_HI:POS_SRC_LO];
  always_comb begin
    src2 = 1'b0;
    unique case (sel2)
      3'h0: src2 = ctl_s[0];
      3'h1: src2 = ctl_s[1];
      3'h2: src2 = ctl_s[4];
      3'h3: src2 = ctl_s[3];
      3'h4: src2 = ctl_s[2];
      3'h5: src2 = ctl_s[2] & ctl_s[3];
      3'h6: src2 = ctl_s[5];
      3'h7: src2 = 1'b1;
    endcase
  end

  assign pg2_vec = {pg_s[PG_LDO3], pg_s[PG_LDO2], pg_s[PG_SW_A1], pg_s[PG_STEP6],
                    pg_s[PG_STEP5], pg_s[PG_STEP4], pg_s[PG_STEP3], pg_s[PG_STEP1]};
  assign pg3_vec = {pg_s[PG_LDO3], pg_s[PG_LDO2], pg_s[PG_SW_A1], pg_s[PG_STEP6],
                    pg_s[PG_STEP5], pg_s[PG_STEP4], pg_s[PG_STEP2], pg_s[PG_STEP1]};

  assign good2 = (&(pg2_vec | mask2_r))
               & (pg_s[PG_PAIR_B2] | src2_r[POS_MASK_PAIR])
               & (pg_s[PG_SW_B1] | src2_r[POS_MASK_B1]);
  assign good3 = &(pg3_vec | mask3_r);

  assign req2 = src2 & good2;
  assign req3 = req3_s & good3;

  assign target_ms = out2_r ? regc_delay_ms(dly2_r[POS_FALL_HI:POS_FALL_LO])
                            : regc_delay_ms(dly2_r[POS_RISE_HI:POS_RISE_LO]);

  // Edge delay machine; live config changes apply to a wait in progress
  always_comb begin
    st_nxt   = st_r;
    out2_nxt = out2_r;
    div_nxt  = div_r;
    ms_nxt   = ms_r;
    unique case (st_r)
      ST_STEADY: begin
        div_nxt = '0;
        ms_nxt  = '0;
        if (req2 != out2_r) begin
          if (target_ms == DLY_MS_0) begin
            out2_nxt = req2;
          end else begin
            st_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Glitch shorter than the delay is swallowed
        if (req2 == out2_r) begin
          st_nxt = ST_STEADY;
        end else if (div_r == DIV_LAST) begin
          div_nxt = '0;
          ms_nxt  = ms_r + 7'h01;
          if (ms_r + 7'h01 >= target_ms) begin
            out2_nxt = req2;
            st_nxt   = ST_STEADY;
          end
        end else begin
          div_nxt = div_r + 18'h00001;
        end
      end
    endcase
    out3_nxt = req3;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r   <= ST_STEADY;
      out2_r <= 1'b0;
      out3_r <= 1'b0;
      div_r  <= '0;
      ms_r   <= '0;
    end else begin
      st_r   <= st_nxt;
      out2_r <= out2_nxt;
      out3_r <= out3_nxt;
      div_r  <= div_nxt;
      ms_r   <= ms_nxt;
    end
  end

  assign rail2_enable = out2_r;
  assign rail3_enable = out3_r;

  // Helper: cycles the request has differed from the output
  logic [31:0] miss_r;
  logic [31:0] exp_cyc;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      miss_r <= 32'h0;
    end else begin
      miss_r <= (req2 != out2_r) ? miss_r + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_src_pair;
    (sel2 == 3'h5) |-> (src2 == (ctl_s[2] & ctl_s[3]));
  endproperty
  a_src_pair: assert property (p_src_pair) else $error("pins 3 and 4 not combined");

  property p_src_pin5;
    (sel2 == 3'h2 && mask2_r == 8'hFF && src2_r[1:0] == 2'h3) |-> (req2 == ctl_s[4]);
  endproperty
  a_src_pin5: assert property (p_src_pin5) else $error("code 2 not pin 5");

  property p_force_on;
    (sel2 == 3'h7 && mask2_r == 8'hFF && src2_r[1:0] == 2'h3) |-> req2;
  endproperty
  a_force_on: assert property (p_force_on) else $error("forced source not on");

  property p_step_write;
    (reg_wr && reg_addr == OFS_RAIL2_SRC) |=> (rail2_vstep_select == $past(reg_wdata[5]));
  endproperty
  a_step_write: assert property (p_step_write) else $error("step bit not written");

  property p_pair_mask;
    (!src2_r[POS_MASK_PAIR] && !pg_s[PG_PAIR_B2]) |-> !req2;
  endproperty
  a_pair_mask: assert property (p_pair_mask) else $error("pair good ignored");

  property p_b1_mask;
    (!src2_r[POS_MASK_B1] && !pg_s[PG_SW_B1]) |-> !req2;
  endproperty
  a_b1_mask: assert property (p_b1_mask) else $error("switch b1 good ignored");

  property p_rail2_mask;
    (!mask2_r[1] && !pg_s[PG_STEP3]) |-> !req2;
  endproperty
  a_rail2_mask: assert property (p_rail2_mask) else $error("step 3 good ignored");

  property p_ldo3_mask;
    (!mask3_r[7] && !pg_s[PG_LDO3]) |=> !rail3_enable;
  endproperty
  a_ldo3_mask: assert property (p_ldo3_mask) else $error("regulator 3 good ignored");

  property p_step2_mask;
    (mask3_r == 8'hFD && req3_s && !pg_s[PG_STEP2]) |=> !rail3_enable;
  endproperty
  a_step2_mask: assert property (p_step2_mask) else $error("step 2 good ignored");

  property p_rise_cause;
    $rose(rail2_enable) |-> $past(req2);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("enable rose without request");

  assign exp_cyc = 32'(int'(target_ms) * MS_CYCLES);

  property p_rise_delay;
    $rose(rail2_enable) && $stable(dly2_r) |-> (miss_r == $past(exp_cyc) + 32'h1);
  endproperty
  a_rise_delay: assert property (p_rise_delay) else $error("rise delay wrong");

  property p_fall_delay;
    $fell(rail2_enable) && $stable(dly2_r) |-> (miss_r == $past(exp_cyc) + 32'h1);
  endproperty
  a_fall_delay: assert property (p_fall_delay) else $error("fall delay wrong");

  property p_tolerance;
    $changed(rail2_enable) && $stable(dly2_r) |->
      (miss_r <= $past(exp_cyc) + $past(exp_cyc) / 32'd10 + 32'h1);
  endproperty
  a_tolerance: assert property (p_tolerance) else $error("delay beyond tolerance");

  property p_rail3_follow;
    rail3_enable == $past(req3);
  endproperty
  a_rail3_follow: assert property (p_rail3_follow) else $error("rail3 not one cycle behind");

  property p_status_read;
    (reg_rd && reg_addr == OFS_STATUS) |=> (reg_rdata[1:0] == {$past(out3_r), $past(out2_r)});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bits wrong");

  // Read data only after a strobe
  property p_rdata_idle;
    !reg_rd |=> (reg_rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");

  c_rise: cover property ($rose(rail2_enable));
  c_fall: cover property ($fell(rail2_enable));
  c_glitch: cover property (st_r == ST_WAIT ##1 st_r == ST_STEADY && !$changed(rail2_enable));
  c_rail3: cover property ($rose(rail3_enable));

endmodule

// ### testbench/regc_partner.sv
// Purpose: pin-side model for the control pins and power-good flags
// Assumes: bench asks for levels; model launches them after a clock edge
// Notes: all levels low in reset, so no rail sees a stale good
`timescale 1ns/1ps
module regc_partner (
  input  wire logic                           mclk,
  input  wire logic                           arst_n,
  input  wire logic [regc_pkg::CTL_COUNT-1:0] ctl_want,
  input  wire logic [regc_pkg::PG_COUNT-1:0]  pg_want,
  input  wire logic                           req_want,
  output logic      [regc_pkg::CTL_COUNT-1:0] control_in,
  output logic      [regc_pkg::PG_COUNT-1:0]  power_good_flag,
  output logic                                rail3_request
);
  import regc_pkg::*;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      control_in      <= '0;
      power_good_flag <= '0;
      rail3_request   <= 1'b0;
    end else begin
      control_in      <= ctl_want;
      power_good_flag <= pg_want;
      rail3_request   <= req_want;
    end
  end
endmodule

// ### testbench/testbench.sv
// Purpose: self-checking bench for rail enable gating
// Assumes: MS_CYCLES of 10, so one ms is ten clocks
// Notes: delays accepted within ten percent plus pin latency
`timescale 1ns/1ps
module testbench;
  import regc_pkg::*;
  localparam int MSC  = 10;
  localparam int CEIL = 20000;
  logic        mclk;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [5:0]  ctl_want;
  logic [10:0] pg_want;
  logic        req_want;
  logic [5:0]  control_in;
  logic [10:0] power_good_flag;
  logic        rail3_request;
  logic        rail2_enable;
  logic        rail3_enable;
  logic        rail2_vstep_select;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          dly_ms [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  logic [5:0]  pin_of [7] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20};
  int          r2_pg [10] = '{0, 2, 3, 4, 5, 6, 7, 8, 10, 9};
  int          r3_pg [8] = '{0, 1, 3, 4, 5, 6, 7, 8};

  regc_partner PART (.mclk(mclk), .arst_n(arst_n), .ctl_want(ctl_want), .pg_want(pg_want),
    .req_want(req_want), .control_in(control_in), .power_good_flag(power_good_flag),
    .rail3_request(rail3_request));
  regc_top #(.MS_CYCLES(MSC)) DUT (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .control_in(control_in), .power_good_flag(power_good_flag),
    .rail3_request(rail3_request), .rail2_enable(rail2_enable),
    .rail3_enable(rail3_enable), .rail2_vstep_select(rail2_vstep_select));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, exp, what);
  endtask

  // Enough clocks for model stage, two sync flops and output register
  task automatic en_chk(input logic e2, input logic e3, input string what);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk({6'h00, rail3_enable, rail2_enable}, {6'h00, e3, e2}, what);
  endtask

  task automatic timed(input logic lvl, input int ms);
    int n;
    n = 0;
    @(posedge mclk);
    ctl_want[0] <= lvl;
    do begin
      @(negedge mclk);
      n++;
    end while (rail2_enable !== lvl && n < 2000);
    num_checks++;
    if (n < ms * MSC * 9 / 10 || n > ms * MSC * 11 / 10 + 6) begin
      n_fail++;
      $display("mismatch at %0t: edge %0b delay %0d ms took %0d", $time, lvl, ms, n);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    arst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    ctl_want = 6'h00; pg_want = 11'h7FF; req_want = 1'b0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rd(8'h0A, 8'h00, "mask3 reset");
    rd(8'h0B, 8'hC0, "src reset");
    rd(8'h0C, 8'h00, "delay reset");
    rd(8'h20, 8'h00, "mask2 reset");
    wr(8'h3F, 8'hFF);
    rd(8'h3F, 8'h00, "unmapped");
    wr(8'h0C, 8'hA5);
    rd(8'h0C, 8'hA5, "delay rw");
    // Step bit set only here, in setup, as the configuration flow would
    wr(8'h0B, 8'h20);
    @(negedge mclk);
    chk({7'h00, rail2_vstep_select}, 8'h01, "step 25mV");
    wr(8'h0B, 8'hC0);
    @(negedge mclk);
    chk({7'h00, rail2_vstep_select}, 8'h00, "step 10mV");
    $display("register test done");
    wr(8'h20, 8'hFF);
    wr(8'h0A, 8'hFF);
    wr(8'h0C, 8'h00);
    req_want <= 1'b1;
    for (int c = 0; c < 7; c++) begin
      wr(8'h0B, 8'(c * 4 + 3));
      ctl_want <= ~pin_of[c];
      en_chk(1'b0, 1'b1, "source off");
      ctl_want <= pin_of[c];
      en_chk(1'b1, 1'b1, "source on");
    end
    wr(8'h0B, 8'h17);
    ctl_want <= 6'h04;
    en_chk(1'b0, 1'b1, "pin 3 alone");
    wr(8'h0B, 8'h1F);
    ctl_want <= 6'h00;
    en_chk(1'b1, 1'b1, "forced on");
    rd(8'h21, 8'h0B, "status");
    $display("source test done");
    wr(8'h0A, 8'h00);
    for (int i = 0; i < 8; i++) begin
      pg_want <= ~(11'h001 << r3_pg[i]);
      en_chk(1'b1, 1'b0, "rail3 good dropped");
      wr(8'h0A, 8'(1 << i));
      en_chk(1'b1, 1'b1, "rail3 good masked");
      wr(8'h0A, 8'h00);
    end
    pg_want <= 11'h7FB;
    en_chk(1'b1, 1'b1, "step3 not in rail3");
    pg_want <= 11'h7FF;
    req_want <= 1'b0;
    en_chk(1'b1, 1'b0, "rail3 request low");
    req_want <= 1'b1;
    wr(8'h0A, 8'hFF);
    wr(8'h20, 8'h00);
    wr(8'h0B, 8'h1C);
    for (int i = 0; i < 10; i++) begin
      pg_want <= ~(11'h001 << r2_pg[i]);
      en_chk(1'b0, 1'b1, "rail2 good dropped");
      if (i < 8) wr(8'h20, 8'(1 << i));
      else wr(8'h0B, 8'(8'h1C + i - 7));
      en_chk(1'b1, 1'b1, "rail2 good masked");
      wr(8'h20, 8'h00);
      wr(8'h0B, 8'h1C);
    end
    pg_want <= 11'h7FD;
    en_chk(1'b1, 1'b1, "step2 not in rail2");
    pg_want <= 11'h7FF;
    $display("mask test done");
    wr(8'h20, 8'hFF);
    wr(8'h0B, 8'h03);
    en_chk(1'b0, 1'b1, "delay idle");
    for (int c = 0; c < 8; c++) begin
      wr(8'h0C, 8'(c * 9));
      timed(1'b1, dly_ms[c]);
      timed(1'b0, dly_ms[c]);
    end
    wr(8'h0C, 8'h03);
    ctl_want <= 6'h01;
    repeat (40) @(posedge mclk);
    ctl_want <= 6'h00;
    en_chk(1'b0, 1'b1, "short pulse");
    repeat (100) @(posedge mclk);
    en_chk(1'b0, 1'b1, "short pulse dropped");
    $display("delay test done");
    end_sim();
  end
endmodule
